// [logic/zdol_pkg.sv]
// zone detection output logic: constants and shared types
package zdol_pkg;

    // ==========================================
    // sizes
    localparam int NUM_SETS   = 32;
    localparam int SET_W      = 5;
    localparam int NUM_ZONES  = 3;
    localparam int ZONE_W     = 2;
    localparam int SCAN_DEG   = 270;
    localparam int STEPS_DEG  = 4;
    localparam int NUM_ANGLES = SCAN_DEG * STEPS_DEG + 1;
    localparam int ANGLE_W    = 11;
    localparam int TIME_W     = 18;
    localparam int DIST_W     = 16;

    // ==========================================
    // zone slots within an area set
    localparam logic [1:0] ZONE_PROT1 = 2'h0;
    localparam logic [1:0] ZONE_SLOT2 = 2'h1;
    localparam logic [1:0] ZONE_SLOT3 = 2'h2;

    // ==========================================
    // ranging and timing
    localparam int LIGHT_UM_PER_PS = 300;
    localparam int UM_PER_MM       = 1000;
    localparam int CLK_HZ          = 20_000_000;
    localparam int SETTLE_MS       = 30;
    localparam int SETTLE_CYC      = SETTLE_MS * (CLK_HZ / 1000);
    localparam int SETTLE_W        = 20;

    // ==========================================
    // reset values
    localparam logic SWITCH_RST = 1'b0;
    localparam logic ALERT_RST  = 1'b0;

    // one beam result from the ranging front end
    typedef struct packed {
        logic               valid;
        logic               scan_end;
        logic [ANGLE_W-1:0] angle;
        logic [TIME_W-1:0]  flight_ps;
    } zdol_meas_t;

    // boundary configuration write
    typedef struct packed {
        logic               we;
        logic [SET_W-1:0]   set;
        logic [ZONE_W-1:0]  zone;
        logic [ANGLE_W-1:0] angle;
        logic [DIST_W-1:0]  limit_mm;
    } zdol_cfg_t;

endpackage

// [logic/zdol_top.sv]
// zone detection output logic: ranging, zone compare, output drive
`timescale 1ns/1ps
module zdol_top #(
    parameter int unsigned SETTLE_CYCLES = zdol_pkg::SETTLE_CYC
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_sys_rst,
    input  wire zdol_pkg::zdol_meas_t       i_meas,
    input  wire zdol_pkg::zdol_cfg_t        i_cfg,
    input  wire logic                       i_dual_mode,
    input  wire logic [zdol_pkg::SET_W-1:0] i_area_sel,
    input  wire logic [zdol_pkg::SET_W-1:0] i_area_sel_inv,
    output logic                            o_zone1_switch_a,
    output logic                            o_zone1_switch_b,
    output logic                            o_zone2_switch_a,
    output logic                            o_zone2_switch_b,
    output logic                            o_first_alert_output,
    output logic                            o_second_alert_output,
    output logic                            o_area_error,
    output logic [zdol_pkg::SET_W-1:0]      o_active_set
);

    localparam int SW = zdol_pkg::SET_W;
    localparam int MEM_DEPTH =
        zdol_pkg::NUM_SETS * zdol_pkg::NUM_ZONES * zdol_pkg::NUM_ANGLES;
    localparam int MEM_AW = 17;
    localparam logic [SW-1:0] SET_ZERO = 5'h00;
    localparam logic [zdol_pkg::SETTLE_W-1:0] SETTLE_LAST =
        zdol_pkg::SETTLE_W'(SETTLE_CYCLES - 1);

    // ==========================================
    // helpers
    function automatic logic [zdol_pkg::DIST_W-1:0] flight_to_mm(
        input logic [zdol_pkg::TIME_W-1:0] t_ps
    );
        logic [31:0] prod;
        prod = 32'(t_ps) * 32'(zdol_pkg::LIGHT_UM_PER_PS);
        // half of light speed times round trip
        return zdol_pkg::DIST_W'(prod / 32'(2 * zdol_pkg::UM_PER_MM));
    endfunction

    function automatic logic [MEM_AW-1:0] bound_addr(
        input logic [SW-1:0]                 set,
        input logic [zdol_pkg::ZONE_W-1:0]   zone,
        input logic [zdol_pkg::ANGLE_W-1:0]  angle
    );
        logic [31:0] a;
        a = (32'(set) * 32'(zdol_pkg::NUM_ZONES) + 32'(zone))
            * 32'(zdol_pkg::NUM_ANGLES) + 32'(angle);
        return MEM_AW'(a);
    endfunction

    // ==========================================
    // boundary store, one limit per set, zone and beam angle
    logic [zdol_pkg::DIST_W-1:0] bound_mem [0:MEM_DEPTH-1];

    always_ff @(posedge i_clk) begin
        if (i_cfg.we && (32'(i_cfg.angle) < 32'(zdol_pkg::NUM_ANGLES))
            && (32'(i_cfg.zone) < 32'(zdol_pkg::NUM_ZONES))) begin
            bound_mem[bound_addr(i_cfg.set, i_cfg.zone, i_cfg.angle)]
                <= i_cfg.limit_mm;
        end
    end

    // ==========================================
    // pin synchronisers
    logic [SW-1:0] sel_s1;
    logic [SW-1:0] sel_s2;
    logic [SW-1:0] inv_s1;
    logic [SW-1:0] inv_s2;
    logic          dual_s1;
    logic          dual_s2;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sel_s1  <= SET_ZERO;
            sel_s2  <= SET_ZERO;
            inv_s1  <= SET_ZERO;
            inv_s2  <= SET_ZERO;
            dual_s1 <= 1'b0;
            dual_s2 <= 1'b0;
        end else begin
            sel_s1  <= i_area_sel;
            sel_s2  <= sel_s1;
            inv_s1  <= i_area_sel_inv;
            inv_s2  <= inv_s1;
            dual_s1 <= i_dual_mode;
            dual_s2 <= dual_s1;
        end
    end

    // ==========================================
    // area selection with settling
    logic [SW-1:0]                 active_set;
    logic [SW-1:0]                 cand_set;
    logic [zdol_pkg::SETTLE_W-1:0] settle_cnt;
    logic                          area_err;
    logic [SW-1:0]                 next_active_set;
    logic [SW-1:0]                 next_cand_set;
    logic [zdol_pkg::SETTLE_W-1:0] next_settle_cnt;
    logic                          next_area_err;
    logic [SW-1:0]                 decoded;
    logic                          pair_bad;

    always_comb begin
        // all inputs on selects the first set
        decoded         = ~sel_s2;
        pair_bad        = (sel_s2 ^ inv_s2) != {SW{1'b1}};
        next_area_err   = pair_bad;
        next_active_set = active_set;
        next_cand_set   = cand_set;
        next_settle_cnt = settle_cnt;
        if (pair_bad) begin
            next_cand_set   = active_set;
            next_settle_cnt = '0;
        end else if (decoded != cand_set) begin
            next_cand_set   = decoded;
            next_settle_cnt = '0;
        end else if (cand_set != active_set) begin
            if (settle_cnt >= SETTLE_LAST) begin
                next_active_set = cand_set;
                next_settle_cnt = '0;
            end else begin
                next_settle_cnt = settle_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            active_set <= SET_ZERO;
            cand_set   <= SET_ZERO;
            settle_cnt <= '0;
            area_err   <= 1'b0;
        end else begin
            active_set <= next_active_set;
            cand_set   <= next_cand_set;
            settle_cnt <= next_settle_cnt;
            area_err   <= next_area_err;
        end
    end

    // ==========================================
    // zone compare for the current beam
    logic [zdol_pkg::DIST_W-1:0] dist_mm;
    logic [zdol_pkg::DIST_W-1:0] lim_p1;
    logic [zdol_pkg::DIST_W-1:0] lim_z2;
    logic [zdol_pkg::DIST_W-1:0] lim_z3;
    logic                        beam_ok;
    logic                        hit_p1;
    logic                        hit_z2;
    logic                        hit_z3;

    always_comb begin
        dist_mm = flight_to_mm(i_meas.flight_ps);
        beam_ok = i_meas.valid
            && (32'(i_meas.angle) < 32'(zdol_pkg::NUM_ANGLES));
        // the selected set supplies every boundary
        lim_p1 = bound_mem[bound_addr(active_set, zdol_pkg::ZONE_PROT1,
                                      i_meas.angle)];
        lim_z2 = bound_mem[bound_addr(active_set, zdol_pkg::ZONE_SLOT2,
                                      i_meas.angle)];
        lim_z3 = bound_mem[bound_addr(active_set, zdol_pkg::ZONE_SLOT3,
                                      i_meas.angle)];
        // a zero limit leaves that angle outside the zone
        hit_p1 = beam_ok && (dist_mm < lim_p1);
        hit_z2 = beam_ok && (dist_mm < lim_z2);
        hit_z3 = beam_ok && (dist_mm < lim_z3) && !dual_s2;
    end

    // ==========================================
    // per-scan hit memory and output drive
    logic scan_p1;
    logic scan_z2;
    logic scan_z3;
    logic sw1;
    logic sw2;
    logic al1;
    logic al2;
    logic next_scan_p1;
    logic next_scan_z2;
    logic next_scan_z3;
    logic next_sw1;
    logic next_sw2;
    logic next_al1;
    logic next_al2;
    logic hit_prot2;
    logic hit_warn1;
    logic hit_warn2;
    logic seen_p1;
    logic seen_z2;
    logic seen_z3;

    always_comb begin
        // slot two is a protection zone only in dual mode
        hit_prot2 = dual_s2 && hit_z2;
        hit_warn1 = !dual_s2 && hit_z2;
        hit_warn2 = hit_z3;
        seen_p1   = scan_p1 || hit_p1;
        seen_z2   = scan_z2 || hit_z2;
        seen_z3   = scan_z3 || hit_z3;
        next_scan_p1 = seen_p1;
        next_scan_z2 = seen_z2;
        next_scan_z3 = seen_z3;
        // switches, a hit turns off at once
        next_sw1 = sw1 && !hit_p1;
        next_sw2 = dual_s2 ? (sw2 && !hit_prot2) : sw1 && !hit_p1;
        // alerts, separate state from the switches
        next_al1 = al1 && !hit_warn1;
        next_al2 = al2 && !hit_warn2;
        if (i_meas.valid && i_meas.scan_end) begin
            // switches back on only after a whole clear scan; in dual mode both alerts are forced on
            next_sw1 = !seen_p1;
            next_sw2 = dual_s2 ? !seen_z2 : !seen_p1;
            next_al1 = dual_s2 ? 1'b1 : !seen_z2;
            next_al2 = dual_s2 ? 1'b1 : !seen_z3;
            next_scan_p1 = 1'b0;
            next_scan_z2 = 1'b0;
            next_scan_z3 = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            scan_p1 <= 1'b0;
            scan_z2 <= 1'b0;
            scan_z3 <= 1'b0;
            sw1     <= zdol_pkg::SWITCH_RST;
            sw2     <= zdol_pkg::SWITCH_RST;
            al1     <= zdol_pkg::ALERT_RST;
            al2     <= zdol_pkg::ALERT_RST;
        end else begin
            scan_p1 <= next_scan_p1;
            scan_z2 <= next_scan_z2;
            scan_z3 <= next_scan_z3;
            sw1     <= next_sw1;
            sw2     <= next_sw2;
            al1     <= next_al1;
            al2     <= next_al2;
        end
    end

    // both members of a pair share one flip-flop
    assign o_zone1_switch_a      = sw1;
    assign o_zone1_switch_b      = sw1;
    assign o_zone2_switch_a      = sw2;
    assign o_zone2_switch_b      = sw2;
    assign o_first_alert_output  = al1;
    assign o_second_alert_output = al2;
    assign o_area_error          = area_err;
    assign o_active_set          = active_set;

endmodule

// [tb/zdol_machine_model.sv]
// machine control model: drives area-select pin pairs
`timescale 1ns/1ps
module zdol_machine_model (
    input  wire logic       i_clk,
    input  wire logic [4:0] i_set,
    input  wire logic       i_break,
    output logic [4:0]      o_area_sel = 5'h1F,
    output logic [4:0]      o_area_sel_inv = 5'h00
);
    // ==========================================
    // pins move together after the falling edge
    always @(negedge i_clk) begin
        o_area_sel <= ~i_set;
        o_area_sel_inv <= i_break ? ~i_set : i_set;
    end
endmodule

// [tb/zdol_props.sv]
// checker: port-level properties of the zone output block
`timescale 1ns/1ps
module zdol_props #(
    parameter int unsigned SETTLE_CYCLES = 8
) (
    input wire logic                 i_clk,
    input wire logic                 i_sys_rst,
    input wire zdol_pkg::zdol_meas_t i_meas,
    input wire logic                 i_dual_mode,
    input wire logic [4:0]           i_area_sel,
    input wire logic [4:0]           i_area_sel_inv,
    input wire logic                 o_zone1_switch_a,
    input wire logic                 o_zone1_switch_b,
    input wire logic                 o_zone2_switch_a,
    input wire logic                 o_zone2_switch_b,
    input wire logic                 o_first_alert_output,
    input wire logic                 o_area_error,
    input wire logic [4:0]           o_active_set
);
    // ==========================================
    // properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire pin_ok   = (i_area_sel == ~i_area_sel_inv);
    wire dual_run = i_dual_mode & ~i_sys_rst;
    wire beam     = i_meas.valid;
    wire end_beam = i_meas.valid & i_meas.scan_end;
    property p_pair1; o_zone1_switch_a == o_zone1_switch_b; endproperty
    a_pair1: assert property (p_pair1) else $error("pair one split");
    property p_pair2; o_zone2_switch_a == o_zone2_switch_b; endproperty
    a_pair2: assert property (p_pair2) else $error("pair two split");
    property p_err_on; (!pin_ok)[*3] |=> o_area_error; endproperty
    a_err_on: assert property (p_err_on) else $error("no pair error");
    property p_err_off; pin_ok[*3] |=> !o_area_error; endproperty
    a_err_off: assert property (p_err_off) else $error("false error");
    property p_sw_on; $rose(o_zone1_switch_a) |-> $past(end_beam); endproperty
    a_sw_on: assert property (p_sw_on) else $error("early on");
    property p_sw_off; $fell(o_zone2_switch_a) |-> $past(beam); endproperty
    a_sw_off: assert property (p_sw_off) else $error("off sans beam");
    property p_al_off;
        $fell(o_first_alert_output) |-> $past(beam);
    endproperty
    a_al_off: assert property (p_al_off) else $error("alert off");
    property p_dual;
        $past(dual_run, 2) && $past(dual_run, 3)
            |-> !$fell(o_first_alert_output);
    endproperty
    a_dual: assert property (p_dual) else $error("dual alert off");
    property p_set;
        $changed(o_active_set) |-> o_active_set == ~$past(i_area_sel, 3)
            && o_active_set == ~$past(i_area_sel, 6);
    endproperty
    a_set: assert property (p_set) else $error("set unsettled");
endmodule
bind zdol_top zdol_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_meas(i_meas),
    .i_dual_mode(i_dual_mode), .i_area_sel(i_area_sel),
    .i_area_sel_inv(i_area_sel_inv),
    .o_zone1_switch_a(o_zone1_switch_a),
    .o_zone1_switch_b(o_zone1_switch_b),
    .o_zone2_switch_a(o_zone2_switch_a),
    .o_zone2_switch_b(o_zone2_switch_b),
    .o_first_alert_output(o_first_alert_output),
    .o_area_error(o_area_error), .o_active_set(o_active_set));

// [tb/zone_detection_output_logic_tb.sv]
// self-checking bench for the zone output block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module zone_detection_output_logic_tb;
    logic                 i_clk = 1'b0;
    logic                 i_sys_rst = 1'b1;
    zdol_pkg::zdol_meas_t i_meas = '0;
    zdol_pkg::zdol_cfg_t  i_cfg = '0;
    logic                 i_dual_mode = 1'b0;
    logic [4:0]           set_req = 5'h00;
    logic [4:0]           cur = 5'h00;
    logic                 brk = 1'b0;
    logic                 se_d = 1'b0;
    logic [4:0]           sel, sel_inv, act;
    logic                 aerr;
    wire  [5:0]           outs;
    logic [5:0]           e6;
    logic [5:0]           expq[$];
    int                   n_fail = 0;
    int                   samples_checked = 0;
    int                   seed = 31547;
    int                   ang[5] = '{0, 1, 540, 1080, 1081};
    always #25 i_clk = ~i_clk;
    zdol_top #(.SETTLE_CYCLES(8)) u_dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_meas(i_meas),
        .i_cfg(i_cfg), .i_dual_mode(i_dual_mode), .i_area_sel(sel),
        .i_area_sel_inv(sel_inv), .o_zone1_switch_a(outs[5]),
        .o_zone1_switch_b(outs[4]), .o_zone2_switch_a(outs[3]),
        .o_zone2_switch_b(outs[2]), .o_first_alert_output(outs[1]),
        .o_second_alert_output(outs[0]), .o_area_error(aerr),
        .o_active_set(act));
    zdol_machine_model u_mach (
        .i_clk(i_clk), .i_set(set_req), .i_break(brk),
        .o_area_sel(sel), .o_area_sel_inv(sel_inv));
    // ==========================================
    // expectation and scan driver
    function automatic logic [15:0] lim(input logic [4:0] s, input int z);
        lim = 16'(z + 1) * 16'h00C8 + ((s == 5'h03) ? 16'h0064 : 16'h0000);
    endfunction
    task automatic scan(input int nb, input bit clr);
        logic [2:0]  h;
        logic [17:0] fl;
        int          k;
        h = 3'h0;
        for (int b = 0; b < nb; b++) begin
            @(negedge i_clk);
            k = {$random(seed)} % 5;
            fl = clr ? 18'h3FFFF : 18'({$random(seed)} % 8000);
            for (int z = 0; z < 3; z++)
                if (k < 4 && (fl * 300) / 2000 < lim(cur, z)) h[z] = 1'b1;
            i_meas = '{1'b1, b == nb - 1, 11'(ang[k]), fl};
        end
        expq.push_back(i_dual_mode ? {{2{~h[0]}}, {2{~h[1]}}, 2'b11}
                                   : {{2{~h[0]}}, {2{~h[0]}}, ~h[1], ~h[2]});
        @(negedge i_clk);
        i_meas = '0;
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================
    // output monitor
    always @(posedge i_clk) se_d <= i_meas.valid && i_meas.scan_end;
    always @(negedge i_clk) begin
        if (se_d && expq.size() > 0) begin
            e6 = expq.pop_front();
            `CHK("switches", e6[5:2], outs[5:2])
            `CHK("alerts", e6[1:0], outs[1:0])
        end
    end
    initial begin
        repeat (6000) @(posedge i_clk);
        n_fail++;
        final_report();
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        for (int n = 0; n < 24; n++) begin
            @(negedge i_clk);
            i_cfg = '{1'b1, (n < 12) ? 5'h00 : 5'h03, 2'(n % 3),
                      11'(ang[(n / 3) % 4]),
                      lim((n < 12) ? 5'h00 : 5'h03, n % 3)};
        end
        @(negedge i_clk);
        i_cfg.we = 1'b0;
        scan(3, 1'b1);
        repeat (20) scan(4, 1'b0);
        i_dual_mode = 1'b1;
        repeat (4) @(negedge i_clk);
        repeat (20) scan(4, 1'b0);
        set_req = 5'h03;
        repeat (6) @(negedge i_clk);
        `CHK("active_set early", 5'h00, act)
        repeat (14) @(negedge i_clk);
        `CHK("active_set", 5'h03, act)
        cur = 5'h03;
        repeat (15) scan(4, 1'b0);
        brk = 1'b1;
        set_req = 5'h00;
        repeat (20) @(negedge i_clk);
        `CHK("area_error", 1'b1, aerr)
        `CHK("active_set held", 5'h03, act)
        brk = 1'b0;
        i_dual_mode = 1'b0;
        repeat (20) @(negedge i_clk);
        `CHK("area_error off", 1'b0, aerr)
        `CHK("active_set back", 5'h00, act)
        cur = 5'h00;
        repeat (15) scan(5, 1'b0);
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        `CHK("reset outputs", 6'h00, outs)
        i_sys_rst = 1'b0;
        scan(2, 1'b1);
        repeat (3) @(negedge i_clk);
        `CHK("pending results", 0, expq.size())
        final_report();
    end
endmodule
